// file: rtl/cfg_readback_defs.svh
`ifndef CFG_READBACK_DEFS_SVH
`define CFG_READBACK_DEFS_SVH
`define DUMMY_WORD 16'hFFFF
`define SYNC_FIRST 16'hAA99
`define SYNC_SECOND 16'h5566
`define IDLE_COMMAND_WORD 16'h2000
`define CMD_WRITE_HDR 16'h30A1
`define RELEASE_SESSION_COMMAND 16'h000D
`define SHUTDOWN_COMMAND 16'h000B
`define START_COMMAND 16'h0005
`define HDR_TYPE_MSB 15
`define HDR_TYPE_LSB 13
`define HDR_OP_MSB 12
`define HDR_OP_LSB 11
`define HDR_ADDR_MSB 10
`define HDR_ADDR_LSB 5
`define HDR_COUNT_MSB 4
`define HDR_COUNT_LSB 0
`define HDR_TYPE1 3'h1
`define OP_READ 2'h1
`define OP_WRITE 2'h2
`define READ_ONE_WORD 5'h01
`define ADDR_FRAME_ADDRESS 6'h01
`define ADDR_FRAME_INPUT 6'h02
`define ADDR_FRAME_READOUT 6'h03
`define ADDR_COMMAND 6'h05
`define ADDR_STATUS 6'h08
`define ADDR_OPTION_ZERO 6'h09
`define OPTION_ZERO_RESET 16'h0001
`define OPT_RETAIN_BIT 0
`define OPT_BRAM9K_BIT 1
`define FRAME_WORDS 16
`define BRAM_FIRST_WORD 4'hC
`define BRAM_INVALID_WORD 16'hFFFF
`define BRAM_CORRUPT_WORD 16'h0000
`define LINK_HALF_CYCLES 3'h4
`define STEP_SAMPLE 5'h0D
`define STEP_LAST 5'h13
`endif

// file: rtl/cfg_readback_pkg.sv
package cfg_readback_pkg;
  typedef enum logic [1:0] {HUNT, SYNC_WAIT, PACKET, WRITE_DATA} dev_state_t;
  typedef enum logic {HOST_IDLE, HOST_RUN} host_state_t;
endpackage : cfg_readback_pkg

// file: rtl/cfg_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfg_port_if;
  logic configurationClock;
  logic chipSelectN;
  logic busDirectionSelect;
  logic [15:0] hostData;
  logic hostDataOeN;
  logic [15:0] deviceData;
  logic deviceDataOeN;
  wire logic [15:0] busData;
  // Weak pull-up when nobody drives
  assign busData = !hostDataOeN ? hostData : (!deviceDataOeN ? deviceData : 16'hFFFF);
  modport device (input configurationClock, input chipSelectN, input busDirectionSelect, input busData,
                  output deviceData, output deviceDataOeN);
  modport host (output configurationClock, output chipSelectN, output busDirectionSelect,
                output hostData, output hostDataOeN, input busData);
endinterface : cfg_port_if
`default_nettype wire

// file: rtl/cfg_host_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_readback_defs.svh"
module cfg_host_end (
  input wire logic clk,
  input wire logic rst,
  cfg_port_if.host port,
  input wire logic startRead,
  input wire logic [5:0] regAddr,
  output logic busy,
  output logic [15:0] readData,
  output logic readDone
);
  cfg_readback_pkg::host_state_t state_reg;
  logic [2:0] halfCnt_reg;
  logic linkClk_reg;
  logic [4:0] step_reg;
  logic [5:0] addr_reg;
  logic csN_reg;
  logic dir_reg;
  logic oeN_reg;
  logic [15:0] data_reg;
  logic [15:0] busMeta_reg;
  logic [15:0] busSync_reg;
  logic [15:0] readData_reg;
  logic readDone_reg;
  logic busy_reg;
  wire logic halfEnd = (halfCnt_reg == (`LINK_HALF_CYCLES - 3'h1));
  wire logic fallTick = halfEnd && linkClk_reg;
  wire logic [15:0] readHeader = {`HDR_TYPE1, `OP_READ, addr_reg, `READ_ONE_WORD};
  wire logic [18:0] stepPins = stepDrive(step_reg, readHeader);

  // Returns {chipSelectN, busDirectionSelect, dataOeN, data}
  function automatic logic [18:0] stepDrive(input logic [4:0] step, input logic [15:0] hdr);
    case (step)
      5'h00, 5'h01: stepDrive = {3'b000, `DUMMY_WORD};
      5'h02: stepDrive = {3'b000, `SYNC_FIRST};
      5'h03: stepDrive = {3'b000, `SYNC_SECOND};
      5'h04: stepDrive = {3'b000, `IDLE_COMMAND_WORD};
      5'h05: stepDrive = {3'b000, hdr};
      5'h06, 5'h07, 5'h08, 5'h09: stepDrive = {3'b000, `IDLE_COMMAND_WORD};
      5'h0A: stepDrive = {3'b101, 16'h0000};
      5'h0B: stepDrive = {3'b111, 16'h0000};
      5'h0C: stepDrive = {3'b011, 16'h0000};
      5'h0D: stepDrive = {3'b111, 16'h0000};
      5'h0E: stepDrive = {3'b101, 16'h0000};
      5'h0F: stepDrive = {3'b000, `CMD_WRITE_HDR};
      5'h10: stepDrive = {3'b000, `RELEASE_SESSION_COMMAND};
      5'h11, 5'h12: stepDrive = {3'b000, `IDLE_COMMAND_WORD};
      default: stepDrive = {3'b101, 16'h0000};
    endcase
  endfunction : stepDrive

  // Link clock divider; pins change only on falling edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halfCnt_reg <= 3'h0;
      linkClk_reg <= 1'b0;
    end else begin
      halfCnt_reg <= halfEnd ? 3'h0 : halfCnt_reg + 3'h1;
      linkClk_reg <= halfEnd ? !linkClk_reg : linkClk_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busMeta_reg <= 16'h0000;
      busSync_reg <= 16'h0000;
    end else begin
      busMeta_reg <= port.busData;
      busSync_reg <= busMeta_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= cfg_readback_pkg::HOST_IDLE;
      step_reg <= 5'h00;
      addr_reg <= 6'h00;
      csN_reg <= 1'b1;
      dir_reg <= 1'b0;
      oeN_reg <= 1'b1;
      data_reg <= 16'h0000;
      readData_reg <= 16'h0000;
      readDone_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      readDone_reg <= 1'b0;
      case (state_reg)
        cfg_readback_pkg::HOST_IDLE: begin
          if (startRead) begin
            state_reg <= cfg_readback_pkg::HOST_RUN;
            busy_reg <= 1'b1;
            addr_reg <= regAddr;
            step_reg <= 5'h00;
          end
        end
        default: begin
          if (fallTick) begin
            {csN_reg, dir_reg, oeN_reg, data_reg} <= stepPins;
            step_reg <= step_reg + 5'h01;
            if (step_reg == `STEP_SAMPLE) begin
              readData_reg <= busSync_reg;
            end
            if (step_reg == `STEP_LAST) begin
              state_reg <= cfg_readback_pkg::HOST_IDLE;
              readDone_reg <= 1'b1;
              busy_reg <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  assign port.configurationClock = linkClk_reg;
  assign port.chipSelectN = csN_reg;
  assign port.busDirectionSelect = dir_reg;
  assign port.hostData = data_reg;
  assign port.hostDataOeN = oeN_reg;
  assign busy = busy_reg;
  assign readData = readData_reg;
  assign readDone = readDone_reg;
endmodule : cfg_host_end
`default_nettype wire

// file: rtl/cfg_device_end.sv
// Behaviour
// - Data pins driven only in read direction
// - Direction change under chip select aborts
// - Host deasserts, toggles direction, then reasserts
// - Chip select sampled on configuration clock
// - Dummy, two sync words, then idle word
// - Type-1 read header names register, count
// - Four idle words flush before reading
// - Read direction presents one word of the read register
// - Host turns bus around around read
// - Command write carries release session code
// - Two idle words follow release command
// - Only readable registers return data
// - Other registers: change header address, count
// - Internal port uses same word ordering
// - Readout returns all cells including memories
// - Memory contents leave through frame readout register
// - Running readback returns invalid RAM data
// - Readback corrupts 9K-mode RAM contents
// - User denied RAM while readback accesses
// - Without retention, port reverts to user I/O
`timescale 1ns/1ps
`default_nettype none
`include "cfg_readback_defs.svh"
module cfg_device_end (
  input wire logic clk,
  input wire logic rst,
  cfg_port_if.device port,
  output logic sessionActive,
  output logic abortPulse,
  output logic userBramDenied,
  output logic portIsUserIo
);
  cfg_readback_pkg::dev_state_t state_reg, state_next;
  logic prevCsN_reg;
  logic prevDir_reg;
  logic abortFlag_reg;
  logic abortToggle_reg;
  logic released_reg, released_next;
  logic shutdown_reg, shutdown_next;
  logic [15:0] option_reg, option_next;
  logic [5:0] rdAddr_reg, rdAddr_next;
  logic [4:0] rdLeft_reg, rdLeft_next;
  logic [5:0] wrAddr_reg, wrAddr_next;
  logic [4:0] wrLeft_reg, wrLeft_next;
  logic [3:0] frameIdx_reg, frameIdx_next;
  logic [15:0] devData_reg;
  logic devOeN_reg;
  logic bramLock_reg;
  logic [15:0] frameMem [0:`FRAME_WORDS-1];

  wire logic csN = port.chipSelectN;
  wire logic dir = port.busDirectionSelect;
  wire logic [15:0] word = port.busData;
  // Word ordering is kept bit for bit, as on the internal port
  wire logic writeStrobe = !csN && !dir && !released_reg;
  wire logic abortEvent = !csN && !prevCsN_reg && (dir != prevDir_reg) && !released_reg;
  wire logic [2:0] hdrType = word[`HDR_TYPE_MSB:`HDR_TYPE_LSB];
  wire logic [1:0] hdrOp = word[`HDR_OP_MSB:`HDR_OP_LSB];
  wire logic [5:0] hdrAddr = word[`HDR_ADDR_MSB:`HDR_ADDR_LSB];
  wire logic [4:0] hdrCount = word[`HDR_COUNT_MSB:`HDR_COUNT_LSB];
  wire logic readable = (hdrAddr == `ADDR_STATUS) || (hdrAddr == `ADDR_OPTION_ZERO)
                        || (hdrAddr == `ADDR_FRAME_READOUT);
  wire logic synced = (state_reg == cfg_readback_pkg::PACKET) || (state_reg == cfg_readback_pkg::WRITE_DATA);
  wire logic syncDone = writeStrobe && (state_reg == cfg_readback_pkg::SYNC_WAIT) && (word == `SYNC_SECOND);
  wire logic readNow = !csN && dir && !released_reg && synced && (rdLeft_reg != 5'h00);
  wire logic inBram = (frameIdx_reg >= `BRAM_FIRST_WORD);
  wire logic frameRead = readNow && (rdAddr_reg == `ADDR_FRAME_READOUT);
  wire logic corruptNow = frameRead && inBram && option_reg[`OPT_BRAM9K_BIT];
  wire logic [15:0] frameWord = (inBram && !shutdown_reg) ? `BRAM_INVALID_WORD : frameMem[frameIdx_reg];
  wire logic [15:0] statusWord = {11'h000, bramLock_reg, released_reg, shutdown_reg, abortFlag_reg, synced};
  wire logic [15:0] readWord = (rdAddr_reg == `ADDR_STATUS) ? statusWord :
                               (rdAddr_reg == `ADDR_OPTION_ZERO) ? option_reg : frameWord;
  wire logic frameWrite = writeStrobe && (state_reg == cfg_readback_pkg::WRITE_DATA)
                          && (wrAddr_reg == `ADDR_FRAME_INPUT);
  wire logic bramLockNext = synced && (rdAddr_reg == `ADDR_FRAME_READOUT) && (rdLeft_reg != 5'h00)
                            && (state_reg == cfg_readback_pkg::PACKET);

  always_comb begin
    state_next = state_reg;
    released_next = released_reg;
    shutdown_next = shutdown_reg;
    option_next = option_reg;
    rdAddr_next = rdAddr_reg;
    rdLeft_next = rdLeft_reg;
    wrAddr_next = wrAddr_reg;
    wrLeft_next = wrLeft_reg;
    frameIdx_next = frameIdx_reg;
    if (abortEvent) begin
      state_next = cfg_readback_pkg::HUNT;
      rdLeft_next = 5'h00;
      wrLeft_next = 5'h00;
    end else if (readNow) begin
      rdLeft_next = rdLeft_reg - 5'h01;
      if (frameRead) begin
        frameIdx_next = frameIdx_reg + 4'h1;
      end
    end else if (writeStrobe) begin
      case (state_reg)
        cfg_readback_pkg::HUNT: begin
          if (word == `SYNC_FIRST) begin
            state_next = cfg_readback_pkg::SYNC_WAIT;
          end
        end
        cfg_readback_pkg::SYNC_WAIT: begin
          if (word == `SYNC_SECOND) begin
            state_next = cfg_readback_pkg::PACKET;
          end else if (word != `SYNC_FIRST) begin
            state_next = cfg_readback_pkg::HUNT;
          end
        end
        cfg_readback_pkg::PACKET: begin
          if (hdrType == `HDR_TYPE1 && hdrOp == `OP_READ) begin
            rdAddr_next = hdrAddr;
            rdLeft_next = readable ? hdrCount : 5'h00;
          end else if (hdrType == `HDR_TYPE1 && hdrOp == `OP_WRITE && hdrCount != 5'h00) begin
            wrAddr_next = hdrAddr;
            wrLeft_next = hdrCount;
            state_next = cfg_readback_pkg::WRITE_DATA;
          end
        end
        default: begin
          wrLeft_next = wrLeft_reg - 5'h01;
          if (wrLeft_reg == 5'h01) begin
            state_next = cfg_readback_pkg::PACKET;
          end
          if (wrAddr_reg == `ADDR_COMMAND) begin
            if (word == `RELEASE_SESSION_COMMAND) begin
              state_next = cfg_readback_pkg::HUNT;
              rdLeft_next = 5'h00;
              wrLeft_next = 5'h00;
              released_next = !option_reg[`OPT_RETAIN_BIT];
            end else if (word == `SHUTDOWN_COMMAND) begin
              shutdown_next = 1'b1;
            end else if (word == `START_COMMAND) begin
              shutdown_next = 1'b0;
            end
          end else if (wrAddr_reg == `ADDR_FRAME_ADDRESS) begin
            frameIdx_next = word[3:0];
          end else if (wrAddr_reg == `ADDR_FRAME_INPUT) begin
            frameIdx_next = frameIdx_reg + 4'h1;
          end else if (wrAddr_reg == `ADDR_OPTION_ZERO) begin
            option_next = word;
          end
        end
      endcase
    end
  end

  always_ff @(posedge port.configurationClock or posedge rst) begin
    if (rst) begin
      state_reg <= cfg_readback_pkg::HUNT;
      prevCsN_reg <= 1'b1;
      prevDir_reg <= 1'b0;
      released_reg <= 1'b0;
      shutdown_reg <= 1'b0;
      option_reg <= `OPTION_ZERO_RESET;
      rdAddr_reg <= 6'h00;
      rdLeft_reg <= 5'h00;
      wrAddr_reg <= 6'h00;
      wrLeft_reg <= 5'h00;
      frameIdx_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      prevCsN_reg <= csN;
      prevDir_reg <= dir;
      released_reg <= released_next;
      shutdown_reg <= shutdown_next;
      option_reg <= option_next;
      rdAddr_reg <= rdAddr_next;
      rdLeft_reg <= rdLeft_next;
      wrAddr_reg <= wrAddr_next;
      wrLeft_reg <= wrLeft_next;
      frameIdx_reg <= frameIdx_next;
    end
  end

  // Abort stays visible until the next sync; a new abort wins
  always_ff @(posedge port.configurationClock or posedge rst) begin
    if (rst) begin
      abortFlag_reg <= 1'b0;
      abortToggle_reg <= 1'b0;
      bramLock_reg <= 1'b0;
      devData_reg <= 16'h0000;
      devOeN_reg <= 1'b1;
    end else begin
      abortFlag_reg <= abortEvent || (abortFlag_reg && !syncDone);
      abortToggle_reg <= abortToggle_reg ^ abortEvent;
      bramLock_reg <= bramLockNext;
      devData_reg <= readNow ? readWord : devData_reg;
      devOeN_reg <= !(dir && !released_reg);
    end
  end

  // Stored RAM changes only by frame input writes or 9K corruption
  always_ff @(posedge port.configurationClock) begin
    if (frameWrite) begin
      frameMem[frameIdx_reg] <= word;
    end else if (corruptNow) begin
      frameMem[frameIdx_reg] <= `BRAM_CORRUPT_WORD;
    end
  end

  // Crossings into the user clock domain
  logic [3:0] levelMeta_reg;
  logic [3:0] levelSync_reg;
  logic abortSeen_reg;
  logic abortPulse_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      levelMeta_reg <= 4'h0;
      levelSync_reg <= 4'h0;
      abortSeen_reg <= 1'b0;
      abortPulse_reg <= 1'b0;
    end else begin
      levelMeta_reg <= {abortToggle_reg, released_reg, bramLock_reg, synced};
      levelSync_reg <= levelMeta_reg;
      abortSeen_reg <= levelSync_reg[3];
      abortPulse_reg <= levelSync_reg[3] ^ abortSeen_reg;
    end
  end

  assign port.deviceData = devData_reg;
  assign port.deviceDataOeN = devOeN_reg;
  assign sessionActive = levelSync_reg[0];
  assign userBramDenied = levelSync_reg[1];
  assign portIsUserIo = levelSync_reg[2];
  assign abortPulse = abortPulse_reg;
endmodule : cfg_device_end
`default_nettype wire

// file: verification/config_port_register_readback_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_readback_defs.svh"
module config_port_register_readback_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic configurationClock,
  input wire logic chipSelectN,
  input wire logic busDirectionSelect,
  input wire logic [15:0] hostData,
  input wire logic hostDataOeN,
  input wire logic [15:0] deviceData,
  input wire logic deviceDataOeN
);
  property p_write_input;
    @(posedge configurationClock) disable iff (rst) !busDirectionSelect |=> deviceDataOeN;
  endproperty
  a_write_input: assert property (p_write_input) else $error("device drives pins in write direction");

  property p_read_drive;
    @(posedge configurationClock) disable iff (rst) busDirectionSelect |=> !deviceDataOeN;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("device does not drive pins in read direction");

  property p_no_contention;
    @(posedge clk) disable iff (rst) !hostDataOeN |-> deviceDataOeN;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("both ends drive the data pins");

  property p_turn;
    @(posedge configurationClock) disable iff (rst)
      $changed(busDirectionSelect) |-> chipSelectN && $past(chipSelectN);
  endproperty
  a_turn: assert property (p_turn) else $error("direction changed with chip select low");

  property p_cs_edge;
    @(posedge clk) disable iff (rst) $changed(chipSelectN) |-> !configurationClock;
  endproperty
  a_cs_edge: assert property (p_cs_edge) else $error("chip select changed in high clock phase");

  property p_sync;
    @(posedge configurationClock) disable iff (rst)
      hostData == `SYNC_SECOND && !chipSelectN && !busDirectionSelect |->
        $past(hostData, 1) == `SYNC_FIRST && $past(hostData, 2) == `DUMMY_WORD ##1 hostData == `IDLE_COMMAND_WORD;
  endproperty
  a_sync: assert property (p_sync) else $error("bad synchronization preamble");

  property p_header_flush;
    @(posedge configurationClock) disable iff (rst)
      hostData[15:13] == `HDR_TYPE1 && hostData[12:11] == `OP_READ && !chipSelectN && !busDirectionSelect |->
        hostData[4:0] == `READ_ONE_WORD ##1 (hostData == `IDLE_COMMAND_WORD && !chipSelectN) [*4]
        ##1 chipSelectN ##1 (chipSelectN && busDirectionSelect) ##1 (!chipSelectN && busDirectionSelect);
  endproperty
  a_header_flush: assert property (p_header_flush) else $error("bad read header, flush or turnaround");

  property p_release;
    @(posedge configurationClock) disable iff (rst)
      hostData == `CMD_WRITE_HDR && !chipSelectN && !busDirectionSelect |=>
        (hostData == `RELEASE_SESSION_COMMAND && !chipSelectN) ##1 (hostData == `IDLE_COMMAND_WORD && !chipSelectN) [*2];
  endproperty
  a_release: assert property (p_release) else $error("bad release session sequence");
endmodule : config_port_register_readback_asserts
`default_nettype wire

// file: verification/test_config_port_register_readback.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_readback_defs.svh"
`define CHECK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module test_config_port_register_readback;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic startRead = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic busy, readDone, sessionActive, abortPulse, userBramDenied, portIsUserIo;
  logic sessionActive2, abortPulse2, portIsUserIo2;
  logic [15:0] readData;
  logic sawSession, sawDenied, sawAbort;
  int errors = 0;
  int checks = 0;
  cfg_port_if link ();
  cfg_port_if link2 ();
  always #2 clk = ~clk;
  cfg_host_end cfg_host_end_i (.clk(clk), .rst(rst), .port(link), .startRead(startRead), .regAddr(regAddr),
    .busy(busy), .readData(readData), .readDone(readDone));
  cfg_device_end cfg_device_end_i (.clk(clk), .rst(rst), .port(link), .sessionActive(sessionActive),
    .abortPulse(abortPulse), .userBramDenied(userBramDenied), .portIsUserIo(portIsUserIo));
  // Second device faced by a bench driver that breaks the turnaround order
  cfg_device_end cfg_device_end_i2 (.clk(clk), .rst(rst), .port(link2), .sessionActive(sessionActive2),
    .abortPulse(abortPulse2), .userBramDenied(), .portIsUserIo(portIsUserIo2));
  config_port_register_readback_asserts config_port_register_readback_asserts_i (.clk(clk), .rst(rst),
    .configurationClock(link.configurationClock), .chipSelectN(link.chipSelectN),
    .busDirectionSelect(link.busDirectionSelect), .hostData(link.hostData), .hostDataOeN(link.hostDataOeN),
    .deviceData(link.deviceData), .deviceDataOeN(link.deviceDataOeN));
  always @(negedge clk) begin
    if (sessionActive === 1'b1) sawSession = 1'b1;
    if (userBramDenied === 1'b1) sawDenied = 1'b1;
    if (abortPulse === 1'b1 || abortPulse2 === 1'b1) sawAbort = 1'b1;
  end
  task automatic results();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic do_read(input logic [5:0] addr);
    int n;
    n = 0;
    @(posedge clk);
    startRead <= 1'b1;
    regAddr <= addr;
    @(posedge clk);
    startRead <= 1'b0;
    @(negedge clk);
    `CHECK(busy, 1'b1)
    while (readDone !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHECK(readDone, 1'b1)
  endtask : do_read
  // Bench-made link clock, still between words
  task automatic send2(input logic [15:0] w, input logic cs, input logic dir);
    link2.chipSelectN <= cs;
    link2.busDirectionSelect <= dir;
    link2.hostData <= w;
    link2.hostDataOeN <= dir;
    #7.5;
    link2.configurationClock <= 1'b1;
    #15;
    link2.configurationClock <= 1'b0;
    #7.5;
  endtask : send2
  task automatic wr2(input logic [15:0] w);
    send2(w, 1'b0, 1'b0);
  endtask : wr2
  // Frame address write
  task automatic seek2(input logic [15:0] idx);
    wr2(16'h3021);
    wr2(idx);
  endtask : seek2
  // Header, legal turnaround, one read word, turnaround back
  task automatic read2(input logic [15:0] hdr, output logic [15:0] got);
    send2(hdr, 1'b0, 1'b0);
    send2(`IDLE_COMMAND_WORD, 1'b1, 1'b0);
    send2(`IDLE_COMMAND_WORD, 1'b1, 1'b1);
    send2(`IDLE_COMMAND_WORD, 1'b0, 1'b1);
    got = link2.deviceData;
    send2(`IDLE_COMMAND_WORD, 1'b1, 1'b1);
    send2(`IDLE_COMMAND_WORD, 1'b1, 1'b0);
  endtask : read2
  // Frame store, shutdown, 9K corruption and port release
  task automatic t_frame_modes();
    logic [15:0] got;
    seek2(16'h000B);
    wr2(16'h3042);
    wr2(16'h1111);
    wr2(16'h2222);
    seek2(16'h000B);
    read2(16'h2861, got);
    `CHECK(got, 16'h1111)
    seek2(16'h000C);
    read2(16'h2861, got);
    `CHECK(got, `BRAM_INVALID_WORD)
    wr2(`CMD_WRITE_HDR);
    wr2(`SHUTDOWN_COMMAND);
    read2(16'h2901, got);
    `CHECK(got, 16'h0005)
    seek2(16'h000C);
    read2(16'h2861, got);
    `CHECK(got, 16'h2222)
    wr2(16'h3121);
    wr2(16'h0003);
    seek2(16'h000C);
    read2(16'h2861, got);
    `CHECK(got, 16'h2222)
    seek2(16'h000C);
    read2(16'h2861, got);
    `CHECK(got, `BRAM_CORRUPT_WORD)
    wr2(16'h3121);
    wr2(16'h0000);
    wr2(`CMD_WRITE_HDR);
    wr2(`RELEASE_SESSION_COMMAND);
    send2(`IDLE_COMMAND_WORD, 1'b1, 1'b1);
    send2(`IDLE_COMMAND_WORD, 1'b0, 1'b1);
    #40;
    `CHECK(portIsUserIo2, 1'b1)
    `CHECK(link2.deviceDataOeN, 1'b1)
    send2(`IDLE_COMMAND_WORD, 1'b1, 1'b0);
  endtask : t_frame_modes
  task automatic t_unreadable_first();
    do_read(`ADDR_COMMAND);
    `CHECK(readData, 16'h0000)
  endtask : t_unreadable_first
  task automatic t_status();
    sawSession = 1'b0;
    sawAbort = 1'b0;
    do_read(`ADDR_STATUS);
    `CHECK(sawAbort, 1'b0)
    `CHECK(readData, 16'h0001)
    `CHECK(sawSession, 1'b1)
    `CHECK(sessionActive, 1'b0)
    `CHECK(portIsUserIo, 1'b0)
    `CHECK(busy, 1'b0)
  endtask : t_status
  task automatic t_back_to_back();
    do_read(`ADDR_OPTION_ZERO);
    `CHECK(readData, `OPTION_ZERO_RESET)
    do_read(`ADDR_COMMAND);
    `CHECK(readData, `OPTION_ZERO_RESET)
  endtask : t_back_to_back
  task automatic t_frame_lock();
    sawDenied = 1'b0;
    do_read(`ADDR_FRAME_READOUT);
    `CHECK(sawDenied, 1'b1)
    `CHECK(sessionActive, 1'b0)
  endtask : t_frame_lock
  task automatic t_abort();
    sawAbort = 1'b0;
    send2(`DUMMY_WORD, 1'b0, 1'b0);
    send2(`SYNC_FIRST, 1'b0, 1'b0);
    send2(`SYNC_SECOND, 1'b0, 1'b0);
    send2(`IDLE_COMMAND_WORD, 1'b0, 1'b0);
    #40;
    `CHECK(sessionActive2, 1'b1)
    send2(`IDLE_COMMAND_WORD, 1'b0, 1'b1);
    send2(`DUMMY_WORD, 1'b1, 1'b0);
    #40;
    `CHECK(sawAbort, 1'b1)
    `CHECK(sessionActive2, 1'b0)
    send2(`IDLE_COMMAND_WORD, 1'b0, 1'b0);
    send2(`SYNC_SECOND, 1'b0, 1'b0);
    #40;
    `CHECK(sessionActive2, 1'b0)
    send2(`DUMMY_WORD, 1'b0, 1'b0);
    send2(`SYNC_FIRST, 1'b0, 1'b0);
    send2(`SYNC_SECOND, 1'b0, 1'b0);
    #40;
    `CHECK(sessionActive2, 1'b1)
  endtask : t_abort
  initial begin
    rst <= 1'b1;
    link2.configurationClock = 1'b0;
    link2.chipSelectN = 1'b1;
    link2.busDirectionSelect = 1'b0;
    link2.hostData = 16'h0000;
    link2.hostDataOeN = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_unreadable_first();
    t_status();
    t_back_to_back();
    t_frame_lock();
    t_abort();
    t_frame_modes();
    results();
  end
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule : test_config_port_register_readback
`default_nettype wire
